// [core/fcsc_pkg.sv]
package fcsc_pkg;

  // ==========================================================================
  // serial interface selection
  typedef enum logic [1:0]
  {
    FCSC_IF_RS232,
    FCSC_IF_RS485_4W,
    FCSC_IF_RS485_2W,
    FCSC_IF_RS422
  } fcsc_iface_t;

  // ==========================================================================
  // contact function selection, two-bit code
  localparam logic [1:0] FCSC_FN_LATCHED = 2'h0;
  localparam logic [1:0] FCSC_FN_SERVICE = 2'h1;
  localparam logic [1:0] FCSC_FN_ACTIVE  = 2'h2;
  localparam logic [1:0] FCSC_FN_SPARE   = 2'h3;

  // ==========================================================================
  // baud rate selection codes
  typedef enum logic [2:0]
  {
    FCSC_BAUD_300,
    FCSC_BAUD_1200,
    FCSC_BAUD_2400,
    FCSC_BAUD_4800,
    FCSC_BAUD_9600,
    FCSC_BAUD_14400,
    FCSC_BAUD_19200,
    FCSC_BAUD_28800
  } fcsc_baud_t;

  // ==========================================================================
  // reset values and character framing
  localparam int          FCSC_ADDR_W       = 8;
  localparam logic [7:0]  FCSC_ADDR_RESET   = 8'h01;
  localparam logic [1:0]  FCSC_FN_RESET     = 2'h0;
  localparam logic [2:0]  FCSC_BAUD_RESET   = 3'h4;
  localparam logic [1:0]  FCSC_IFACE_RESET  = 2'h0;
  localparam int          FCSC_START_BITS   = 1;
  localparam int          FCSC_DATA_BITS    = 8;
  localparam int          FCSC_STOP_BITS    = 1;
  localparam int          FCSC_CLK_HZ       = 25000000;

  // divider in system clocks for one bit time at a given rate
  function automatic logic [16:0] fcsc_bit_div(input logic [2:0] code);
    int rate;
    begin
      rate = 9600;
      case (code)
        3'h0:    rate = 300;
        3'h1:    rate = 1200;
        3'h2:    rate = 2400;
        3'h3:    rate = 4800;
        3'h4:    rate = 9600;
        3'h5:    rate = 14400;
        3'h6:    rate = 19200;
        3'h7:    rate = 28800;
        default: rate = 9600;
      endcase
      fcsc_bit_div = 17'(FCSC_CLK_HZ / rate);
    end
  endfunction : fcsc_bit_div

endpackage : fcsc_pkg

// [core/fcsc_top.sv]
`timescale 1ns/1ps
`default_nettype none

module fcsc_top
  import fcsc_pkg::*;
(
  // clock and reset
  input  wire  logic                    i_clk_sys,
  input  wire  logic                    i_rst,
  // configuration writes from the protocol engine
  input  wire  logic                    i_cfg_we,
  input  wire  fcsc_pkg::fcsc_iface_t   i_cfg_iface,
  input  wire  logic [7:0]              i_cfg_addr,
  input  wire  logic [1:0]              i_cfg_fn,
  input  wire  fcsc_pkg::fcsc_baud_t    i_cfg_baud,
  // serial commands, one-cycle pulses
  input  wire  logic                    i_cmd_fault_reset,
  input  wire  logic                    i_cmd_clr_srq,
  // amplifier conditions, asynchronous levels
  input  wire  logic                    i_fault,
  input  wire  logic                    i_attention,
  // configuration readback
  output logic [1:0]                    o_iface,
  output logic [7:0]                    o_addr,
  output logic [1:0]                    o_fn,
  output logic [2:0]                    o_baud,
  output logic [16:0]                   o_bit_div,
  output logic [3:0]                    o_char_bits,
  // contact drive, high means fault indicated, or a service request when the service function is selected
  output logic                          o_contact
);

  // ==========================================================================
  // state
  // every register of the block lives in this one struct, so reset and the
  // clocked update cannot drift apart; the flags keep their own bits apart
  // from the contact so that a function change never loses what was seen
  // while another function was selected
  typedef struct packed
  {
    // condition pin synchronisers and filtered levels
    logic [2:0]  fault_sync;
    logic [2:0]  attn_sync;
    logic        fault_f;
    logic        attn_f;
    // configuration held for the protocol engine and the line driver
    logic [1:0]  iface;
    logic [7:0]  addr;
    logic [1:0]  fn;
    logic [2:0]  baud;
    // indication flags and the registered contact
    logic        latch;
    logic        srq;
    logic        contact;
  } fcsc_state_t;

  fcsc_state_t st_r;
  fcsc_state_t st_nxt;

  // ==========================================================================
  // helper functions
  // pin filter: a level only moves once stages two and three agree, so a
  // single-cycle glitch that reaches stage two never reaches the contact
  function automatic logic fcsc_filter(input logic [2:0] sync, input logic level);
    logic res;
    begin
      res = level;
      if (sync[1] == sync[2])
      begin
        res = sync[2];
      end
      fcsc_filter = res;
    end
  endfunction : fcsc_filter

  // fault reset only counts while the filtered fault is gone; a reset sent
  // during a live fault is dropped, the host has to send it again later
  function automatic logic fcsc_reset_ok(input logic cmd, input logic fault_lvl);
    begin
      fcsc_reset_ok = cmd && !fault_lvl;
    end
  endfunction : fcsc_reset_ok

  // contact source for the selected function; the spare code falls back to
  // latched so an unexpected setting never hides a fault
  function automatic logic fcsc_contact_sel(
    input logic [1:0] fn,
    input logic       latch,
    input logic       srq,
    input logic       fault_lvl
  );
    logic res;
    begin
      res = latch;
      case (fn)
        FCSC_FN_LATCHED: res = latch;
        FCSC_FN_SERVICE: res = srq;
        FCSC_FN_ACTIVE:  res = fault_lvl;
        FCSC_FN_SPARE:   res = latch;
        default:         res = latch;
      endcase
      fcsc_contact_sel = res;
    end
  endfunction : fcsc_contact_sel

  // ==========================================================================
  // command qualification
  // all of these read the registered filtered levels, never the raw pins,
  // so a fault present in the cycle of a command still wins over it
  logic fault_reset_ok;
  logic srq_clear;
  logic latch_set;
  logic srq_set;

  assign fault_reset_ok = fcsc_reset_ok(i_cmd_fault_reset, st_r.fault_f);
  assign srq_clear      = i_cmd_clr_srq || fault_reset_ok;
  assign latch_set      = st_r.fault_f;
  assign srq_set        = st_r.attn_f || st_r.fault_f;

  // ==========================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;

    // three-stage sync on the asynchronous condition pins
    st_nxt.fault_sync = {st_r.fault_sync[1:0], i_fault};
    st_nxt.attn_sync  = {st_r.attn_sync[1:0], i_attention};

    // filtered levels, they trail the first stage by three cycles
    st_nxt.fault_f = fcsc_filter(st_r.fault_sync, st_r.fault_f);
    st_nxt.attn_f  = fcsc_filter(st_r.attn_sync, st_r.attn_f);

    // configuration: all four settings load together on one write
    if (i_cfg_we)
    begin
      st_nxt.iface = i_cfg_iface;
      st_nxt.addr  = i_cfg_addr;
      st_nxt.fn    = i_cfg_fn;
      st_nxt.baud  = i_cfg_baud;
    end

    // latched fault: clear first, set after, so a set in the same cycle wins
    if (fault_reset_ok)
    begin
      st_nxt.latch = 1'b0;
    end
    if (latch_set)
    begin
      st_nxt.latch = 1'b1;
    end

    // service request: cleared by either command, set wins the same way
    if (srq_clear)
    begin
      st_nxt.srq = 1'b0;
    end
    if (srq_set)
    begin
      st_nxt.srq = 1'b1;
    end

    // contact follows the new flag values, so a set shows on the same edge
    // as the flag; a function change lands one cycle after the write
    st_nxt.contact = fcsc_contact_sel(st_r.fn, st_nxt.latch, st_nxt.srq, st_r.fault_f);
  end

  // ==========================================================================
  // registers; sync reset puts the documented defaults in place
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st_r         <= '0;
      st_r.addr    <= FCSC_ADDR_RESET;
      st_r.fn      <= FCSC_FN_RESET;
      st_r.baud    <= FCSC_BAUD_RESET;
      st_r.iface   <= FCSC_IFACE_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs, from flip-flops, a decode of them, or a constant
  // the bit divider is a pure decode of the baud register, so it changes
  // on the same edge as the readback; the character length never changes
  assign o_iface     = st_r.iface;
  assign o_addr      = st_r.addr;
  assign o_fn        = st_r.fn;
  assign o_baud      = st_r.baud;
  assign o_bit_div   = fcsc_bit_div(st_r.baud);
  assign o_char_bits = 4'(FCSC_START_BITS + FCSC_DATA_BITS + FCSC_STOP_BITS);
  assign o_contact   = st_r.contact;

endmodule : fcsc_top

`default_nettype wire

// [verification/fcsc_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// contact and readback checks
module fcsc_chk (
  input wire logic i_clk_sys, i_rst, i_cfg_we, i_fault, i_cmd_fault_reset, i_cmd_clr_srq, o_contact,
  input wire logic [7:0] i_cfg_addr, o_addr,
  input wire logic [1:0] i_cfg_fn, o_fn
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // seven samples clear the five edge filter path with margin
  property p_rst; $fell(i_rst) |-> o_addr == 8'h01; endproperty
  a_rst: assert property (p_rst) else $error("reset addr");
  property p_adr; i_cfg_we |=> o_addr == $past(i_cfg_addr); endproperty
  a_adr: assert property (p_adr) else $error("addr load");
  property p_hld; !i_cfg_we |=> $stable(o_addr); endproperty
  a_hld: assert property (p_hld) else $error("addr hold");
  property p_fn; i_cfg_we |=> o_fn == $past(i_cfg_fn); endproperty
  a_fn: assert property (p_fn) else $error("fn load");
  property p_set; i_fault [*7] |-> o_contact; endproperty
  a_set: assert property (p_set) else $error("no contact");
  property p_act; (o_fn == 2'h2 && !i_fault) [*7] |-> !o_contact; endproperty
  a_act: assert property (p_act) else $error("active stuck");
  property p_ref; i_fault [*7] ##0 i_cmd_fault_reset |=> o_contact; endproperty
  a_ref: assert property (p_ref) else $error("reset taken");
  property p_kep; o_contact && o_fn != 2'h2 && $stable(o_fn) && !i_cmd_fault_reset && !i_cmd_clr_srq |=> o_contact;
  endproperty
  a_kep: assert property (p_kep) else $error("latch lost");
  c_act: cover property (o_fn == 2'h2 && o_contact);
  c_srq: cover property (o_fn == 2'h1 && i_cmd_clr_srq && o_contact);
  c_lat: cover property (o_fn == 2'h3 && $fell(o_contact));
endmodule : fcsc_chk
bind fcsc_top fcsc_chk i_fcsc_chk (.i_clk_sys, .i_rst, .i_cfg_we, .i_fault, .i_cmd_fault_reset, .i_cmd_clr_srq,
  .o_contact, .i_cfg_addr, .o_addr, .i_cfg_fn, .o_fn);
`default_nettype wire

// [verification/fcsc_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side of the serial link
module fcsc_host (
  input  wire logic       i_req,
  input  wire logic [7:0] i_d,
  input  wire logic [1:0] i_f,
  output logic            o_we,
  output logic [7:0]      o_ad,
  output var fcsc_pkg::fcsc_iface_t o_if
);
  import fcsc_pkg::*;
  // zero barred, units may share a bus
  assign o_we = i_req;
  assign o_ad = (i_d == 8'h00) ? 8'h01 : i_d;
  assign o_if = fcsc_iface_t'(i_f);
endmodule : fcsc_host
`default_nettype wire

// [verification/test_fcsc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_fcsc_top;
  import fcsc_pkg::*;
  // ==========
  // stimulus and readback
  logic i_clk_sys = 1'b0, i_rst = 1'b1, rq = 1'b0, fr = 1'b0, cs = 1'b0, fa = 1'b0, at = 1'b0, o_contact, we;
  logic [7:0] d = 8'h00, ad, o_addr;
  logic [1:0] f = 2'h0, o_iface, o_fn;
  logic [2:0] b = 3'h0, o_baud;
  logic [3:0] o_char_bits;
  logic [16:0] o_bit_div;
  logic [31:0] s = 32'h5CD89067;
  fcsc_iface_t ifc;
  int n_mismatch = 0, checked = 0, rt[8] = '{300, 1200, 2400, 4800, 9600, 14400, 19200, 28800};
  // clock
  always #20 i_clk_sys = ~i_clk_sys;
  fcsc_host i_fcsc_host (.i_req(rq), .i_d(d), .i_f(f), .o_we(we), .o_ad(ad), .o_if(ifc));
  fcsc_top i_fcsc_top (.i_clk_sys, .i_rst, .i_cfg_we(we), .i_cfg_iface(ifc), .i_cfg_addr(ad), .i_cfg_fn(f),
    .i_cfg_baud(fcsc_baud_t'(b)), .i_cmd_fault_reset(fr), .i_cmd_clr_srq(cs), .i_fault(fa), .i_attention(at),
    .o_iface, .o_addr, .o_fn, .o_baud, .o_bit_div, .o_char_bits, .o_contact);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input logic [16:0] g, input int e);
    checked++;
    if (g !== 17'(e))
    begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cfg(input int k);
    @(posedge i_clk_sys);
    s = xs(s);
    d <= s[7:0];
    f <= k[1:0];
    b <= k[2:0];
    rq <= 1'b1;
    @(posedge i_clk_sys);
    rq <= 1'b0;
    @(negedge i_clk_sys);
  endtask : cfg
  // levels and command pulses, then settle past the filter
  task automatic st(input logic x, y, p, q);
    @(posedge i_clk_sys);
    fa <= x;
    at <= y;
    fr <= p;
    cs <= q;
    @(posedge i_clk_sys);
    fr <= 1'b0;
    cs <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : st
  task automatic summarize();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // main sequence: reset values, every code, every contact mode
  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_addr, 1);
    chk(o_bit_div, 2604);
    chk(o_char_bits, 10);
    chk(o_fn, 0);
    chk(o_baud, 4);
    for (int k = 0; k < 8; k++)
    begin
      cfg(k);
      chk(o_addr, (s[7:0] == 0) ? 1 : s[7:0]);
      chk(o_iface, k % 4);
      chk(o_bit_div, 25000000 / rt[k]);
      chk(o_fn, k % 4);
      chk(o_baud, k);
    end
    for (int m = 0; m < 4; m++)
    begin
      cfg(m);
      st(1, 0, 1, 0);
      chk(o_contact, 1);
      st(1, 0, 1, 0);
      chk(o_contact, 1);
      st(0, 0, 0, 0);
      chk(o_contact, m != 2);
      st(0, 1, 1, 0);
      chk(o_contact, m == 1);
      st(0, 0, 0, 0);
      chk(o_contact, m == 1);
      st(0, 0, 0, 1);
      chk(o_contact, 0);
    end
    summarize();
  end
  // watchdog, the run needs some 300 cycles
  initial
  begin
    #100us;
    n_mismatch++;
    summarize();
  end
endmodule : test_fcsc_top
`default_nettype wire
